// ===== src/pmw_defs.svh
// Timing and encoding constants of the power mode and reset sequencer
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH
`define PMW_CLK_MHZ          200
`define PMW_IRC_START_NS     60000
`define PMW_IRC_WAIT_CYC     4
`define PMW_FLASH_START_NS   100000
`define PMW_IRC_MHZ          12
`define PMW_OSC_WAIT_CYC     4096
`define PMW_RST_CLKS         64
`define PMW_RST_SYNC_STAGES  3
`define PMW_EINT_EDGE_NUM    30
`define PMW_CLKSEL_SYSCLK    1'b0
`define PMW_DIV_RESET        8'h00
`endif

// ===== src/pmw_pkg.sv
// Types shared by the power mode and reset sequencer
package pmw_pkg;
  typedef enum logic [2:0] {
    PMW_RUN       = 3'b000,
    PMW_DSLEEP    = 3'b001,
    PMW_PDOWN     = 3'b010,
    PMW_DPDOWN    = 3'b011,
    PMW_WAKE_OSC  = 3'b100,
    PMW_WAKE_CNT  = 3'b101
  } pmw_state_t;
  typedef enum logic [1:0] {
    PMW_REQ_NONE   = 2'b00,
    PMW_REQ_DSLEEP = 2'b01,
    PMW_REQ_PDOWN  = 2'b10
  } pmw_req_t;
endpackage : pmw_pkg

// ===== src/pmw_sync_if.sv
// Carrier between the sequencer and its synchroniser
interface pmw_sync_if #(parameter int W = 1);
  logic [W-1:0] async_in;
  logic [W-1:0] level;
  logic [W-1:0] changed;
  modport sync (input async_in, output level, output changed);
  modport user (output async_in, input level, input changed);
endinterface : pmw_sync_if

// ===== src/pmw_sync.sv
// Three-stage input synchroniser with agreement of the last two stages
module pmw_sync #(
  parameter int W = 1
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  pmw_sync_if.sync  sif
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;
  wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
  wire  [W-1:0] nxt_lvl = (agree & s3_ff) | (~agree & lvl_ff);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff  <= sif.async_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign sif.level   = lvl_ff;
  assign sif.changed = nxt_lvl ^ lvl_ff;
endmodule : pmw_sync

// ===== src/pmw_seq.sv
// Power mode, wake-up and reset sequencer
`include "pmw_defs.svh"
module pmw_seq #(
  parameter int IRQ_W       = 64,
  parameter int EINT_N      = `PMW_EINT_EDGE_NUM,
  parameter int IRC_START_C =
    (`PMW_IRC_START_NS * `PMW_CLK_MHZ + 999) / 1000,
  parameter int FLASH_C     =
    (`PMW_FLASH_START_NS * `PMW_IRC_MHZ + 999) / 1000,
  parameter int OSC_WAIT_C  = `PMW_OSC_WAIT_CYC,
  parameter int DIV_W       = 8,
  parameter int NDIV        = 4
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   reset_pin_n,
  input  wire logic                   wdt_reset,
  input  wire logic                   wdt_running,
  input  wire logic                   por_reset,
  input  wire logic                   bod_stage1,
  input  wire logic                   bod_stage2,
  input  wire logic                   osc_running,
  input  wire logic                   flash_init_done,
  input  wire pmw_pkg::pmw_req_t      sleep_req,
  input  wire logic                   main_osc_sel,
  input  wire logic [IRQ_W-1:0]       nested_vector_irq_ctrl_mask,
  input  wire logic [IRQ_W-1:0]       irq_lines,
  input  wire logic                   rtc_enabled,
  input  wire logic                   rtc_irq,
  input  wire logic                   rtc_dpd_req,
  input  wire logic                   rtc_alarm,
  input  wire logic                   keep_32k_osc,
  input  wire logic [EINT_N-1:0]      eint_edge,
  input  wire logic                   eint_level,
  input  wire logic [EINT_N:0]        eint_wake_en,
  input  wire logic                   flash_req,
  output logic                        flash_ready,
  output logic                        chip_reset_n,
  output logic                        boot_addr_zero,
  output logic                        cpu_wake,
  output logic                        cpu_run,
  output logic                        irc_on,
  output logic                        main_osc_on,
  output logic                        clocks_on,
  output logic                        pll_on,
  output logic                        clksel,
  output logic                        div_clear,
  output logic                        flash_pd,
  output logic                        wdt_clk_on,
  output logic                        rtc_clk_on,
  output logic                        osc32k_on,
  output logic                        core_power_on,
  output logic                        bod_irq,
  output logic                        bod_status
);
  import pmw_pkg::*;

  // ----------------------------------------------------------------
  // Reset source combining and release
  // ----------------------------------------------------------------
  localparam int RW = 16;
  logic [`PMW_RST_SYNC_STAGES-1:0] rsync_ff;
  logic [RW-1:0]    rcnt_ff;
  logic             rel_ff;
  logic [RW-1:0]    nxt_rcnt;

  pmw_sync_if #(.W(EINT_N + 4)) sif ();
  pmw_sync #(.W(EINT_N + 4)) u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .sif     (sif)
  );
  assign sif.async_in = {eint_level, eint_edge, rtc_alarm,
                         ~reset_pin_n, bod_stage1};

  wire bod1_s   = sif.level[0];
  wire pin_s    = sif.level[1];
  wire alarm_s  = sif.level[2];
  wire alarm_ev = sif.changed[2] & ~alarm_s;
  wire [EINT_N-1:0] eint_rise = sif.changed[EINT_N+2:3]
                              & ~sif.level[EINT_N+2:3];
  wire eint_lvl_s = sif.level[EINT_N+3];

  wire any_src = pin_s | wdt_reset | por_reset | bod_stage2;
  wire rst_ok  = ~any_src & osc_running & flash_init_done
               & (rcnt_ff == RW'(`PMW_RST_CLKS));

  assign nxt_rcnt = any_src | ~osc_running ? '0 :
                    (rcnt_ff == RW'(`PMW_RST_CLKS)) ? rcnt_ff :
                    rcnt_ff + RW'(1);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsync_ff <= '0;
      rcnt_ff  <= '0;
      rel_ff   <= 1'b0;
    end else begin
      rcnt_ff  <= nxt_rcnt;
      rel_ff   <= rst_ok;
      rsync_ff <= any_src ? '0 :
                  {rsync_ff[`PMW_RST_SYNC_STAGES-2:0], rel_ff};
    end
  end

  wire int_rst = ~rsync_ff[`PMW_RST_SYNC_STAGES-1];
  assign chip_reset_n   = ~int_rst;
  assign boot_addr_zero = int_rst;

  // ----------------------------------------------------------------
  // Brownout stage one
  // ----------------------------------------------------------------
  assign bod_irq    = bod1_s;
  assign bod_status = bod1_s;

  // ----------------------------------------------------------------
  // Wake sources and catcher
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] wmask_ff;
  logic [EINT_N:0]  eint_hit;
  assign eint_hit = {eint_lvl_s, eint_rise} & eint_wake_en;
  wire wic_hit  = |(irq_lines & wmask_ff);
  wire rtc_wake = rtc_enabled & rtc_irq;
  wire any_wake = wic_hit | rtc_wake | (|eint_hit);

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  localparam int CW = 16;
  pmw_state_t st_ff;
  pmw_state_t nxt_st;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [CW-1:0] fcnt_ff;
  logic          from_pd_ff;
  logic          osc32_ff;

  wire [CW-1:0] ds_wait = main_osc_sel ? CW'(OSC_WAIT_C)
                                       : CW'(`PMW_IRC_WAIT_CYC);
  wire cnt_done = (cnt_ff == '0);

  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff == '0 ? cnt_ff : cnt_ff - CW'(1);
    unique case (st_ff)
      PMW_RUN: begin
        if (rtc_dpd_req) begin
          nxt_st = PMW_DPDOWN;
        end else if (sleep_req == PMW_REQ_PDOWN) begin
          nxt_st = PMW_PDOWN;
        end else if (sleep_req == PMW_REQ_DSLEEP) begin
          nxt_st = PMW_DSLEEP;
        end
      end
      PMW_DSLEEP: begin
        if (any_wake) begin
          nxt_st  = PMW_WAKE_CNT;
          nxt_cnt = ds_wait;
        end
      end
      PMW_PDOWN: begin
        if (any_wake) begin
          nxt_st  = PMW_WAKE_OSC;
          nxt_cnt = CW'(IRC_START_C);
        end
      end
      PMW_DPDOWN: begin
        if (alarm_ev) begin
          nxt_st  = PMW_WAKE_OSC;
          nxt_cnt = CW'(IRC_START_C);
        end
      end
      PMW_WAKE_OSC: begin
        if (cnt_done) begin
          nxt_st  = PMW_WAKE_CNT;
          nxt_cnt = CW'(`PMW_IRC_WAIT_CYC);
        end
      end
      PMW_WAKE_CNT: begin
        if (cnt_done) begin
          nxt_st = PMW_RUN;
        end
      end
      default: begin
        nxt_st = PMW_RUN;
      end
    endcase
  end

  wire enter_low = (st_ff == PMW_RUN) & (nxt_st != PMW_RUN);
  wire enter_pd  = (st_ff == PMW_RUN)
                 & ((nxt_st == PMW_PDOWN) | (nxt_st == PMW_DPDOWN));
  wire sleeping  = (st_ff == PMW_DSLEEP) | (st_ff == PMW_PDOWN)
                 | (st_ff == PMW_DPDOWN);
  wire pd_like   = (st_ff == PMW_PDOWN) | (st_ff == PMW_DPDOWN);
  wire fl_load   = (st_ff == PMW_WAKE_OSC) & from_pd_ff & (fcnt_ff == '0);

  // ----------------------------------------------------------------
  // RC oscillator rate enable for the flash counter
  // ----------------------------------------------------------------
  // Rounded up and restarted on load so flash is never released early
  localparam int DV   = (`PMW_CLK_MHZ + `PMW_IRC_MHZ - 1) / `PMW_IRC_MHZ;
  localparam int DVW  = 8;
  logic [DVW-1:0] dv_ff;
  wire irc_tick = (dv_ff == DVW'(DV - 1));
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dv_ff <= '0;
    end else begin
      dv_ff <= (irc_tick | fl_load) ? '0 : dv_ff + DVW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff      <= PMW_RUN;
      cnt_ff     <= '0;
      wmask_ff   <= '0;
      fcnt_ff    <= '0;
      from_pd_ff <= 1'b0;
      osc32_ff   <= 1'b1;
    end else if (int_rst) begin
      st_ff      <= PMW_RUN;
      cnt_ff     <= '0;
      wmask_ff   <= '0;
      fcnt_ff    <= '0;
      from_pd_ff <= 1'b0;
      osc32_ff   <= 1'b1;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
      if (enter_low) begin
        wmask_ff <= nested_vector_irq_ctrl_mask;
      end
      if (nxt_st == PMW_DPDOWN && st_ff == PMW_RUN) begin
        osc32_ff <= keep_32k_osc;
      end else if (nxt_st == PMW_RUN) begin
        osc32_ff <= 1'b1;
      end
      if (enter_pd) begin
        from_pd_ff <= 1'b1;
      end else if (fl_load) begin
        fcnt_ff    <= CW'(FLASH_C);
        from_pd_ff <= 1'b0;
      end else if (fcnt_ff != '0 && irc_tick) begin
        fcnt_ff <= fcnt_ff - CW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Flash gating and control outputs
  // ----------------------------------------------------------------
  wire flash_busy = (fcnt_ff != '0) | from_pd_ff | pd_like | int_rst;
  assign flash_ready   = flash_req & ~flash_busy;
  assign flash_pd      = pd_like | from_pd_ff;
  assign cpu_wake      = (st_ff == PMW_DPDOWN) ? alarm_ev
                                               : sleeping & any_wake;
  assign cpu_run       = (st_ff == PMW_RUN) & ~int_rst;
  assign irc_on        = ~pd_like;
  assign main_osc_on   = ~pd_like & ~(st_ff == PMW_DSLEEP);
  assign clocks_on     = ~sleeping;
  assign pll_on        = 1'b0;
  assign clksel        = `PMW_CLKSEL_SYSCLK;
  assign div_clear     = enter_low | int_rst;
  assign wdt_clk_on    = wdt_running & (st_ff != PMW_DPDOWN);
  assign rtc_clk_on    = rtc_enabled;
  assign osc32k_on     = osc32_ff;
  assign core_power_on = st_ff != PMW_DPDOWN;
endmodule : pmw_seq

// ===== verification/pmw_seq_assertions.sv
// Concurrent checks on the ports of the power mode and reset sequencer
`include "pmw_defs.svh"
module pmw_seq_chk
  import pmw_pkg::*;
(
  input wire logic     ref_clk,
  input wire logic     reset_n,
  input wire logic     reset_pin_n,
  input wire logic     wdt_reset,
  input wire logic     por_reset,
  input wire logic     bod_stage1,
  input wire logic     bod_stage2,
  input wire logic     flash_init_done,
  input wire pmw_req_t sleep_req,
  input wire logic     rtc_dpd_req,
  input wire logic     flash_ready,
  input wire logic     chip_reset_n,
  input wire logic     boot_addr_zero,
  input wire logic     cpu_run,
  input wire logic     irc_on,
  input wire logic     main_osc_on,
  input wire logic     clocks_on,
  input wire logic     pll_on,
  input wire logic     clksel,
  input wire logic     div_clear,
  input wire logic     flash_pd,
  input wire logic     core_power_on,
  input wire logic     bod_irq,
  input wire logic     bod_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_pd;
    cpu_run && sleep_req == PMW_REQ_PDOWN && !rtc_dpd_req;
  endsequence
  property p_pd_clk;
    s_pd |=> !irc_on && !clocks_on && !main_osc_on;
  endproperty
  a_pd_clk: assert property (p_pd_clk) else $error("clock on");
  property p_pd_pll;
    s_pd |=> !pll_on && clksel == `PMW_CLKSEL_SYSCLK;
  endproperty
  a_pd_pll: assert property (p_pd_pll) else $error("pll on");
  property p_pd_div;
    s_pd |-> ##[0:1] div_clear;
  endproperty
  a_pd_div: assert property (p_pd_div) else $error("no div clear");
  property p_pd_flash;
    s_pd |=> flash_pd;
  endproperty
  a_pd_flash: assert property (p_pd_flash) else $error("flash up");
  property p_src;
    wdt_reset || por_reset || bod_stage2 |-> ##[0:5] !chip_reset_n;
  endproperty
  a_src: assert property (p_src) else $error("reset missed");
  property p_rel;
    $rose(chip_reset_n) |-> flash_init_done && $past(reset_pin_n, 8);
  endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_boot;
    !chip_reset_n ##1 !chip_reset_n |-> boot_addr_zero && !cpu_run
      && !flash_ready;
  endproperty
  a_boot: assert property (p_boot) else $error("boot state");
  property p_bod;
    bod_stage1 [*5] |-> bod_irq && bod_status;
  endproperty
  a_bod: assert property (p_bod) else $error("bod flag");
  property p_fl;
    flash_ready |-> !flash_pd && chip_reset_n;
  endproperty
  a_fl: assert property (p_fl) else $error("flash ready early");
  c_pd: cover property (s_pd);
  c_dpd: cover property ($fell(core_power_on));
  c_rel: cover property ($rose(chip_reset_n));
endmodule : pmw_seq_chk

bind pmw_seq pmw_seq_chk i_pmw_seq_chk (.*);

// ===== verification/pmw_far_model.sv
// Model of interrupt controller, flash controller and fetching core
module pmw_far_model (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        cpu_run,
  input  wire logic        flash_ready,
  input  wire logic [63:0] en_mask,
  output logic             flash_init_done,
  output logic             osc_running,
  output logic             flash_req,
  output logic [63:0]      nested_vector_irq_ctrl_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  // Top four lines never have priority to preempt a sleeping core
  localparam logic [63:0] PRIO_OK = 64'h0fff_ffff_ffff_ffff;
  logic [7:0] init_ff;
  assign flash_init_done = init_ff == 8'h28;
  assign osc_running = init_ff >= 8'h0a;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      init_ff <= 8'h00;
      flash_req <= 1'b0;
      nested_vector_irq_ctrl_mask <= '0;
    end else begin
      if (!flash_init_done) init_ff <= init_ff + 8'h01;
      nested_vector_irq_ctrl_mask <= en_mask & PRIO_OK;
      // A fetch is held until flash answers ready
      if (flash_req && flash_ready) flash_req <= 1'b0;
      else if (cpu_run) flash_req <= 1'b1;
    end
  end
endmodule : pmw_far_model

// ===== verification/pmw_seq_tb.sv
// Self-checking bench of the power mode and reset sequencer
`include "pmw_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module pmw_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmw_pkg::*;
  localparam int IRC_C = 20;
  localparam int FL_C = 10;
  localparam int OSC_C = 8;
  logic ref_clk = 0, reset_n, reset_pin_n = 1, wdt_reset = 0, por_reset = 0;
  logic wdt_running = 1, bod_stage1 = 0, bod_stage2 = 0, main_osc_sel = 0;
  logic rtc_enabled = 1, rtc_irq = 0, rtc_dpd_req = 0, rtc_alarm = 0;
  logic keep_32k_osc = 0, eint_level = 0, osc_running, flash_init_done;
  logic flash_req, flash_ready, chip_reset_n, boot_addr_zero, cpu_wake;
  logic cpu_run, irc_on, main_osc_on, clocks_on, pll_on, clksel, div_clear;
  logic flash_pd, wdt_clk_on, rtc_clk_on, osc32k_on, core_power_on;
  logic bod_irq, bod_status;
  logic [63:0] nested_vector_irq_ctrl_mask, irq_lines = '0, en_mask = '0;
  logic [29:0] eint_edge = '0;
  logic [30:0] eint_wake_en = '1;
  pmw_req_t sleep_req = PMW_REQ_NONE;
  logic [31:0] seed = 32'hc4441fee;
  int num_errors = 0, n_checks = 0, c, f, i, k, e;
  always #2.5 ref_clk = ~ref_clk;
  pmw_seq #(.IRC_START_C(IRC_C), .FLASH_C(FL_C), .OSC_WAIT_C(OSC_C))
    i_pmw_seq (.*);
  pmw_far_model i_pmw_far_model (.ref_clk(ref_clk), .reset_n(reset_n),
    .cpu_run(cpu_run), .flash_ready(flash_ready), .en_mask(en_mask),
    .flash_init_done(flash_init_done), .osc_running(osc_running),
    .flash_req(flash_req), .nested_vector_irq_ctrl_mask(nested_vector_irq_ctrl_mask));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic int exp_wake(input int mode, input logic osc);
    if (mode == 2) return IRC_C + `PMW_IRC_WAIT_CYC;
    return osc ? OSC_C : 4;
  endfunction : exp_wake
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wait_hi(input bit fl, output int n);
    n = 0;
    while ((fl ? flash_ready : cpu_run) !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
  endtask : wait_hi
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    reset_n = 0;
    tick(8);
    reset_n = 1;
    `CHK("boot_zero", 1'b1, boot_addr_zero)
    for (i = 0; i < 5; i++) begin
      {por_reset, wdt_reset, bod_stage2, reset_pin_n} =
        4'b0001 ^ (4'b0001 << (i % 4));
      tick(6);
      `CHK("src_reset", 1'b0, chip_reset_n)
      {por_reset, wdt_reset, bod_stage2, reset_pin_n} = 4'b0001;
      wait_hi(0, c);
      `CHK("release", 1'b1, c >= `PMW_RST_CLKS && flash_init_done)
    end
    bod_stage1 = 1;
    tick(5);
    `CHK("bod", 3'b111, {bod_irq, bod_status, chip_reset_n})
    bod_stage1 = 0;
    for (k = 0; k < 12; k++) begin
      seed = xs(seed);
      en_mask = {seed, xs(seed)} & ~64'h1 | 64'h2;
      main_osc_sel = seed[0];
      wdt_running = seed[3];
      tick(2);
      sleep_req = (k % 3 == 2) ? PMW_REQ_PDOWN : PMW_REQ_DSLEEP;
      tick(1);
      sleep_req = PMW_REQ_NONE;
      irq_lines[0] = 1;
      tick(3);
      `CHK("masked", 2'b00, {cpu_wake, cpu_run})
      irq_lines[0] = 0;
      if (k % 3 == 2) begin
        `CHK("pd_clk", 3'b000, {clocks_on, irc_on, main_osc_on})
        `CHK("pd_flash", 1'b1, flash_pd)
        `CHK("pd_wdt", seed[3], wdt_clk_on)
        `CHK("pd_rtc", 1'b1, rtc_clk_on)
        `CHK("pd_pwr", 1'b1, core_power_on)
      end
      case (seed[2:1])
        2'd0: irq_lines[1] = 1;
        2'd1: eint_edge[seed[8:4] % 30] = 1;
        2'd2: eint_level = 1;
        default: rtc_irq = 1;
      endcase
      #1;
      if (seed[2:1] == 2'd0) `CHK("catch", 1'b1, cpu_wake)
      e = exp_wake(k % 3, seed[0]);
      wait_hi(0, c);
      `CHK("wake_time", 1'b1, c >= e && c <= e + 6)
      if (k % 3 == 2) begin
        tick(1);
        `CHK("stall", 2'b10, {flash_req, flash_ready})
        wait_hi(1, f);
        e = FL_C * `PMW_CLK_MHZ / `PMW_IRC_MHZ;
        `CHK("flash_time", 1'b1, c + f >= e - 2 && c + f <= e + 8)
      end
      irq_lines = '0;
      eint_edge = '0;
      {eint_level, rtc_irq} = 2'b00;
      tick(8);
    end
    for (k = 0; k < 2; k++) begin
      keep_32k_osc = k[0];
      rtc_dpd_req = 1;
      tick(1);
      rtc_dpd_req = 0;
      tick(5);
      `CHK("dpd_pwr", 1'b0, core_power_on)
      `CHK("dpd_32k", k[0], osc32k_on)
      irq_lines[1] = 1;
      tick(6);
      `CHK("dpd_hold", 3'b000, {core_power_on, cpu_run, cpu_wake})
      irq_lines[1] = 0;
      {rtc_alarm, reset_pin_n} = {~k[0], ~k[0]};
      tick(6);
      {rtc_alarm, reset_pin_n} = 2'b01;
      wait_hi(0, c);
      `CHK("dpd_exit", 2'b11, {core_power_on, cpu_run})
    end
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end
endmodule : pmw_seq_tb
